// ==== dsb_signaling_regs.vh ====
`ifndef DSB_SIGNALING_REGS_VH
`define DSB_SIGNALING_REGS_VH

// Register offsets, framer page 1
`define DSB_RX_SIG_C_CH16_9 9'h189
`define DSB_RX_SIG_C_CH24_17 9'h18A
`define DSB_RX_SIG_D_CH8_1 9'h18C
`define DSB_RX_SIG_D_CH16_9 9'h18D
`define DSB_RX_SIG_D_CH24_17 9'h18E
`define DSB_TX_SIG_A_CH8_1 9'h1D0
`define DSB_TX_SIG_A_CH16_9 9'h1D1
`define DSB_TX_SIG_A_CH24_17 9'h1D2
`define DSB_TX_SIG_B_CH8_1 9'h1D4
`define DSB_TX_SIG_B_CH16_9 9'h1D5
`define DSB_TX_SIG_B_CH24_17 9'h1D6
`define DSB_TX_SIG_C_CH8_1 9'h1D8
`define DSB_TX_SIG_C_CH16_9 9'h1D9

// Reset values and read answer
`define DSB_SIG_RESET 8'h00
`define DSB_UNMAPPED_READ 8'h00

// Highway slot layout: letters per channel, channel count
`define DSB_HWY_BITS_PER_CH 3'h4
`define DSB_HWY_LAST_BIT 2'h3
`define DSB_FIRST_CH 5'h01
`define DSB_LAST_CH 5'h18
`define DSB_HIGH_C_CH 5'h10

`endif

// ==== dsb_sig_bank.v ====
`timescale 1ns/10ps
module dsb_sig_bank #(
  parameter NCH = 16,
  parameter FIRST_CH = 9,
  parameter ZERO_OFF = 1
) (
  input wire sys_clk,
  input wire reset,
  input wire [NCH-1:0] chan_en,
  input wire line_we,
  input wire [4:0] line_ch,
  input wire line_bit,
  input wire cpu_we,
  input wire [1:0] cpu_grp,
  input wire [7:0] cpu_wdata,
  output reg [NCH-1:0] state
);

  reg [NCH-1:0] next_state;
  integer i;

  // Bit i holds channel FIRST_CH+i, so bit 7 of each group is its highest channel
  always @* begin
    next_state = state;
    for (i = 0; i < NCH; i = i + 1) begin
      if ((ZERO_OFF != 0) && !chan_en[i]) begin
        // RL4 RL9 - zero disabled channel
        next_state[i] = 1'b0;
      end else if (cpu_we && (cpu_grp == (i / 8)) && (chan_en[i] || (ZERO_OFF == 0))) begin
        // RL8 RL9 - processor update, gated
        next_state[i] = cpu_wdata[i % 8];
      end else if (line_we && chan_en[i] && (line_ch == (FIRST_CH + i))) begin
        // RL3 RL6 - enabled channel stores
        next_state[i] = line_bit;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      state <= {NCH{1'b0}};
    end else begin
      state <= next_state;
    end
  end

endmodule

// ==== dsb_signaling_regs.v ====
// Overview of operation
// RL1 - Receive register shows eight channels of one letter, highest channel at bit 7.
// RL2 - Transmit register holds eight channels of one letter, highest channel at bit 7.
// RL3 - Enabled channel stores its received signaling state in the receive buffer.
// RL4 - Disabled channel gets zeros in its receive C and D entries.
// RL5 - Transmit buffer loads from the serial highway; system drives A, B, C, D.
// RL6 - Enabled channel stores its highway signaling state in the transmit buffer.
// RL7 - Disabled channel gets no robbed-bit insertion from the transmit buffer.
// RL8 - Host may write new signaling states through these registers while frozen.
// RL9 - Disabling clears receive states and blocks line, processor and insertion updates; transmit banks still take processor writes for disabled channels.
`timescale 1ns/10ps
`include "dsb_signaling_regs.vh"
module dsb_signaling_regs (
  input wire sys_clk,
  input wire reset,
  input wire [23:0] channel_signal_enable,
  input wire [8:0] cpu_addr,
  input wire cpu_wr,
  input wire cpu_rd,
  input wire [7:0] cpu_wdata,
  output reg [7:0] cpu_rdata,
  output reg cpu_rd_ack,
  output reg cpu_addr_miss,
  input wire rx_sig_we,
  input wire [4:0] rx_sig_ch,
  input wire rx_sig_c,
  input wire rx_sig_d,
  input wire tx_hwy_sync,
  input wire tx_hwy_bit_en,
  input wire tx_hwy_bit,
  input wire tx_ins_req,
  input wire [4:0] tx_ins_ch,
  output reg tx_ins_valid,
  output reg tx_ins_en,
  output reg tx_ins_a,
  output reg tx_ins_b,
  output reg tx_ins_c
);

  wire [15:0] rx_c_state;
  wire [23:0] rx_d_state;
  wire [23:0] tx_a_state;
  wire [23:0] tx_b_state;
  wire [15:0] tx_c_state;

  // Address decode
  wire hit_rx_c0 = (cpu_addr == `DSB_RX_SIG_C_CH16_9);
  wire hit_rx_c1 = (cpu_addr == `DSB_RX_SIG_C_CH24_17);
  wire hit_rx_d0 = (cpu_addr == `DSB_RX_SIG_D_CH8_1);
  wire hit_rx_d1 = (cpu_addr == `DSB_RX_SIG_D_CH16_9);
  wire hit_rx_d2 = (cpu_addr == `DSB_RX_SIG_D_CH24_17);
  wire hit_tx_a0 = (cpu_addr == `DSB_TX_SIG_A_CH8_1);
  wire hit_tx_a1 = (cpu_addr == `DSB_TX_SIG_A_CH16_9);
  wire hit_tx_a2 = (cpu_addr == `DSB_TX_SIG_A_CH24_17);
  wire hit_tx_b0 = (cpu_addr == `DSB_TX_SIG_B_CH8_1);
  wire hit_tx_b1 = (cpu_addr == `DSB_TX_SIG_B_CH16_9);
  wire hit_tx_b2 = (cpu_addr == `DSB_TX_SIG_B_CH24_17);
  wire hit_tx_c0 = (cpu_addr == `DSB_TX_SIG_C_CH8_1);
  wire hit_tx_c1 = (cpu_addr == `DSB_TX_SIG_C_CH16_9);

  wire hit_rx_c = hit_rx_c0 | hit_rx_c1;
  wire hit_rx_d = hit_rx_d0 | hit_rx_d1 | hit_rx_d2;
  wire hit_tx_a = hit_tx_a0 | hit_tx_a1 | hit_tx_a2;
  wire hit_tx_b = hit_tx_b0 | hit_tx_b1 | hit_tx_b2;
  wire hit_tx_c = hit_tx_c0 | hit_tx_c1;
  wire hit_any = hit_rx_c | hit_rx_d | hit_tx_a | hit_tx_b | hit_tx_c;

  // Group index within each letter bank
  wire [1:0] grp_rx_c = hit_rx_c1 ? 2'h1 : 2'h0;
  wire [1:0] grp_rx_d = hit_rx_d2 ? 2'h2 : (hit_rx_d1 ? 2'h1 : 2'h0);
  wire [1:0] grp_tx_a = hit_tx_a2 ? 2'h2 : (hit_tx_a1 ? 2'h1 : 2'h0);
  wire [1:0] grp_tx_b = hit_tx_b2 ? 2'h2 : (hit_tx_b1 ? 2'h1 : 2'h0);
  wire [1:0] grp_tx_c = hit_tx_c1 ? 2'h1 : 2'h0;

  // Out of range line channels are dropped, not aliased
  wire rx_ch_ok = (rx_sig_ch >= `DSB_FIRST_CH) && (rx_sig_ch <= `DSB_LAST_CH);

  // Serial highway: sync marks the A bit of channel 1, then A, B, C, D per channel
  reg [4:0] hwy_ch;
  reg [1:0] hwy_bit_idx;
  reg [2:0] hwy_shift;
  reg hwy_active;
  reg hwy_done;
  reg [4:0] hwy_done_ch;
  reg [3:0] hwy_word;
  reg [4:0] next_hwy_ch;
  reg [1:0] next_hwy_bit_idx;
  reg next_hwy_active;

  always @* begin
    next_hwy_ch = hwy_ch;
    next_hwy_bit_idx = hwy_bit_idx;
    next_hwy_active = hwy_active;
    // A sync mid-frame drops the partial word and restarts at channel 1
    if (tx_hwy_sync) begin
      next_hwy_active = 1'b1;
      next_hwy_ch = `DSB_FIRST_CH;
      next_hwy_bit_idx = 2'h0;
      if (tx_hwy_bit_en) begin
        next_hwy_bit_idx = 2'h1;
      end
    end else if (hwy_active && tx_hwy_bit_en) begin
      if (hwy_bit_idx == `DSB_HWY_LAST_BIT) begin
        next_hwy_bit_idx = 2'h0;
        if (hwy_ch == `DSB_LAST_CH) begin
          // Wait for the next sync after channel 24
          next_hwy_active = 1'b0;
        end else begin
          next_hwy_ch = hwy_ch + 5'h01;
        end
      end else begin
        next_hwy_bit_idx = hwy_bit_idx + 2'h1;
      end
    end
  end

  // RL5 - deserialise highway slots
  always @(posedge sys_clk) begin
    if (reset) begin
      hwy_ch <= `DSB_FIRST_CH;
      hwy_bit_idx <= 2'h0;
      hwy_active <= 1'b0;
      hwy_shift <= 3'h0;
      hwy_done <= 1'b0;
      hwy_done_ch <= `DSB_FIRST_CH;
      hwy_word <= 4'h0;
    end else begin
      hwy_ch <= next_hwy_ch;
      hwy_bit_idx <= next_hwy_bit_idx;
      hwy_active <= next_hwy_active;
      hwy_done <= 1'b0;
      if (tx_hwy_bit_en && (tx_hwy_sync || hwy_active)) begin
        if (tx_hwy_sync || (hwy_bit_idx != `DSB_HWY_LAST_BIT)) begin
          hwy_shift <= tx_hwy_sync ? {2'h0, tx_hwy_bit} : {hwy_shift[1:0], tx_hwy_bit};
        end else begin
          // Word is A, B, C, D from msb down
          hwy_word <= {hwy_shift, tx_hwy_bit};
          hwy_done <= 1'b1;
          hwy_done_ch <= hwy_ch;
        end
      end
    end
  end

  // RL1 RL3 RL4 - receive C, channels 9 to 16 and 17 to 24
  dsb_sig_bank #(.NCH(16), .FIRST_CH(9), .ZERO_OFF(1)) u_rx_c (
    .sys_clk(sys_clk),
    .reset(reset),
    .chan_en(channel_signal_enable[23:8]),
    .line_we(rx_sig_we & rx_ch_ok),
    .line_ch(rx_sig_ch),
    .line_bit(rx_sig_c),
    .cpu_we(cpu_wr & hit_rx_c),
    .cpu_grp(grp_rx_c),
    .cpu_wdata(cpu_wdata),
    .state(rx_c_state)
  );

  // RL1 RL3 RL4 - receive D, all channels
  dsb_sig_bank #(.NCH(24), .FIRST_CH(1), .ZERO_OFF(1)) u_rx_d (
    .sys_clk(sys_clk),
    .reset(reset),
    .chan_en(channel_signal_enable),
    .line_we(rx_sig_we & rx_ch_ok),
    .line_ch(rx_sig_ch),
    .line_bit(rx_sig_d),
    .cpu_we(cpu_wr & hit_rx_d),
    .cpu_grp(grp_rx_d),
    .cpu_wdata(cpu_wdata),
    .state(rx_d_state)
  );

  // RL2 RL6 - transmit A from highway
  dsb_sig_bank #(.NCH(24), .FIRST_CH(1), .ZERO_OFF(0)) u_tx_a (
    .sys_clk(sys_clk),
    .reset(reset),
    .chan_en(channel_signal_enable),
    .line_we(hwy_done),
    .line_ch(hwy_done_ch),
    .line_bit(hwy_word[3]),
    .cpu_we(cpu_wr & hit_tx_a),
    .cpu_grp(grp_tx_a),
    .cpu_wdata(cpu_wdata),
    .state(tx_a_state)
  );

  // RL2 RL6 - transmit B from highway
  dsb_sig_bank #(.NCH(24), .FIRST_CH(1), .ZERO_OFF(0)) u_tx_b (
    .sys_clk(sys_clk),
    .reset(reset),
    .chan_en(channel_signal_enable),
    .line_we(hwy_done),
    .line_ch(hwy_done_ch),
    .line_bit(hwy_word[2]),
    .cpu_we(cpu_wr & hit_tx_b),
    .cpu_grp(grp_tx_b),
    .cpu_wdata(cpu_wdata),
    .state(tx_b_state)
  );

  // RL2 RL6 - transmit C, channels 1 to 16 only
  dsb_sig_bank #(.NCH(16), .FIRST_CH(1), .ZERO_OFF(0)) u_tx_c (
    .sys_clk(sys_clk),
    .reset(reset),
    .chan_en(channel_signal_enable[15:0]),
    .line_we(hwy_done),
    .line_ch(hwy_done_ch),
    .line_bit(hwy_word[1]),
    .cpu_we(cpu_wr & hit_tx_c),
    .cpu_grp(grp_tx_c),
    .cpu_wdata(cpu_wdata),
    .state(tx_c_state)
  );

  // Read mux; a read in the same cycle as a write returns the old value
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = `DSB_UNMAPPED_READ;
    if (hit_rx_c0) begin
      next_rdata = rx_c_state[7:0];
    end else if (hit_rx_c1) begin
      next_rdata = rx_c_state[15:8];
    end else if (hit_rx_d0) begin
      next_rdata = rx_d_state[7:0];
    end else if (hit_rx_d1) begin
      next_rdata = rx_d_state[15:8];
    end else if (hit_rx_d2) begin
      next_rdata = rx_d_state[23:16];
    end else if (hit_tx_a0) begin
      next_rdata = tx_a_state[7:0];
    end else if (hit_tx_a1) begin
      next_rdata = tx_a_state[15:8];
    end else if (hit_tx_a2) begin
      next_rdata = tx_a_state[23:16];
    end else if (hit_tx_b0) begin
      next_rdata = tx_b_state[7:0];
    end else if (hit_tx_b1) begin
      next_rdata = tx_b_state[15:8];
    end else if (hit_tx_b2) begin
      next_rdata = tx_b_state[23:16];
    end else if (hit_tx_c0) begin
      next_rdata = tx_c_state[7:0];
    end else if (hit_tx_c1) begin
      next_rdata = tx_c_state[15:8];
    end
  end

  // Read data held between reads, so a slow host may sample late
  always @(posedge sys_clk) begin
    if (reset) begin
      cpu_rdata <= `DSB_SIG_RESET;
      cpu_rd_ack <= 1'b0;
      cpu_addr_miss <= 1'b0;
    end else begin
      cpu_rd_ack <= cpu_rd;
      cpu_addr_miss <= (cpu_rd | cpu_wr) & ~hit_any;
      if (cpu_rd) begin
        cpu_rdata <= next_rdata;
      end
    end
  end

  // Robbed-bit insertion lookup
  wire [4:0] ins_idx = tx_ins_ch - 5'h01;
  wire ins_ch_ok = (tx_ins_ch >= `DSB_FIRST_CH) && (tx_ins_ch <= `DSB_LAST_CH);
  wire ins_c_ok = (tx_ins_ch <= `DSB_HIGH_C_CH);
  // Padded to 32 so an out of range channel never indexes past the banks
  wire [31:0] en_pad = {8'h00, channel_signal_enable};
  wire [31:0] a_pad = {8'h00, tx_a_state};
  wire [31:0] b_pad = {8'h00, tx_b_state};
  wire ins_on = ins_ch_ok && en_pad[ins_idx];
  // Channel of the answer now held on the insertion outputs
  reg [4:0] ins_last_idx;
  // A held answer must not outlive its enable, or a dropped channel keeps inserting
  wire ins_drop = tx_ins_en && !en_pad[ins_last_idx];

  always @(posedge sys_clk) begin
    if (reset) begin
      tx_ins_valid <= 1'b0;
      tx_ins_en <= 1'b0;
      tx_ins_a <= 1'b0;
      tx_ins_b <= 1'b0;
      tx_ins_c <= 1'b0;
      ins_last_idx <= 5'h00;
    end else begin
      tx_ins_valid <= tx_ins_req;
      if (tx_ins_req) begin
        // RL7 RL9 - no insertion when disabled
        tx_ins_en <= ins_on;
        tx_ins_a <= ins_on & a_pad[ins_idx];
        tx_ins_b <= ins_on & b_pad[ins_idx];
        tx_ins_c <= ins_on & ins_c_ok & tx_c_state[ins_idx[3:0]];
        ins_last_idx <= ins_idx;
      end else if (ins_drop) begin
        // RL7 RL9 - withdraw on enable fall
        tx_ins_en <= 1'b0;
        tx_ins_a <= 1'b0;
        tx_ins_b <= 1'b0;
        tx_ins_c <= 1'b0;
      end
    end
  end

endmodule

// ==== dsb_signaling_regs_chk.sv ====
`timescale 1ns/10ps
module dsb_signaling_regs_chk (
  input logic sys_clk,
  input logic reset,
  input logic [23:0] channel_signal_enable,
  input logic [8:0] cpu_addr,
  input logic cpu_rd,
  input logic [7:0] cpu_rdata,
  input logic cpu_rd_ack,
  input logic cpu_addr_miss,
  input logic tx_ins_req,
  input logic [4:0] tx_ins_ch,
  input logic tx_ins_valid,
  input logic tx_ins_en,
  input logic tx_ins_a,
  input logic tx_ins_b,
  input logic tx_ins_c
);
  logic [23:0] en_q;
  // Enable a cycle back, so a freshly dropped enable is not judged early
  always @(posedge sys_clk) en_q <= channel_signal_enable;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_rd_answer: assert property (cpu_rd |=> cpu_rd_ack) else $error("read not answered");
  a_ack_cause: assert property (cpu_rd_ack |-> $past(cpu_rd)) else $error("stray read answer");
  a_miss_read: assert property (cpu_rd && cpu_addr == 9'h188 |=> cpu_addr_miss && cpu_rdata == 8'h00)
    else $error("unmapped read wrong");
  a_rx_zeroed: assert property (cpu_rd && cpu_addr == 9'h18C && (channel_signal_enable[7:0] | en_q[7:0]) == 8'h00
    |=> cpu_rdata == 8'h00) else $error("disabled receive bits not zero");
  a_ins_answer: assert property (tx_ins_req |=> tx_ins_valid) else $error("insertion not answered");
  a_ins_blocked: assert property (tx_ins_req && (tx_ins_ch == 5'h00 || tx_ins_ch > 5'h18
    || !channel_signal_enable[tx_ins_ch - 5'h01]) |=> {tx_ins_en, tx_ins_a, tx_ins_b, tx_ins_c} == 4'h0)
    else $error("disabled channel inserts");
  a_ins_enabled: assert property (tx_ins_req && tx_ins_ch inside {[1:24]}
    && channel_signal_enable[tx_ins_ch - 5'h01] |=> tx_ins_en) else $error("enabled channel refused");
  a_ins_c_high: assert property (tx_ins_req && tx_ins_ch > 5'h10 |=> !tx_ins_c) else $error("C kept above 16");
endmodule
bind dsb_signaling_regs dsb_signaling_regs_chk chk_u (.sys_clk(sys_clk), .reset(reset),
  .channel_signal_enable(channel_signal_enable), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
  .cpu_rd_ack(cpu_rd_ack), .cpu_addr_miss(cpu_addr_miss), .tx_ins_req(tx_ins_req), .tx_ins_ch(tx_ins_ch),
  .tx_ins_valid(tx_ins_valid), .tx_ins_en(tx_ins_en), .tx_ins_a(tx_ins_a), .tx_ins_b(tx_ins_b), .tx_ins_c(tx_ins_c));

// ==== dsb_hwy_src.sv ====
`timescale 1ns/10ps
module dsb_hwy_src (
  input wire logic sys_clk,
  output logic sync,
  output logic bit_en,
  output logic hbit
);
  initial begin
    sync = 1'b0;
    bit_en = 1'b0;
    hbit = 1'b0;
  end
  task send(input [23:0] a, input [23:0] b, input [23:0] c, input [23:0] d, input int gap);
    int ch;
    int k;
    logic [3:0] q;
    for (ch = 0; ch < 24; ch++) begin
      q = {d[ch], c[ch], b[ch], a[ch]};
      for (k = 0; k < 4; k++) begin
        @(negedge sys_clk);
        sync = (ch == 0 && k == 0);
        bit_en = 1'b1;
        hbit = q[k];
        // Gaps toggle the bit each cycle, so every second gap cycle shows the last valid bit again
        repeat (gap) begin
          @(negedge sys_clk);
          sync = 1'b0;
          bit_en = 1'b0;
          hbit = ~hbit;
        end
      end
    end
    @(negedge sys_clk);
    sync = 1'b0;
    bit_en = 1'b0;
    hbit = ~hbit;
  endtask
endmodule

// ==== dsb_signaling_regs_tb.sv ====
`timescale 1ns/10ps
module dsb_signaling_regs_tb;
  logic sys_clk, reset, cpu_wr, cpu_rd, rx_sig_we, rx_sig_c, rx_sig_d, tx_ins_req;
  logic [23:0] channel_signal_enable;
  logic [8:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata;
  logic [4:0] rx_sig_ch, tx_ins_ch;
  logic cpu_rd_ack, cpu_addr_miss, tx_hwy_sync, tx_hwy_bit_en, tx_hwy_bit;
  logic tx_ins_valid, tx_ins_en, tx_ins_a, tx_ins_b, tx_ins_c;
  logic [8:0] regs [13] = '{9'h189, 9'h18A, 9'h18C, 9'h18D, 9'h18E, 9'h1D0, 9'h1D1, 9'h1D2, 9'h1D4, 9'h1D5,
    9'h1D6, 9'h1D8, 9'h1D9};
  int fails, checks_done;
  dsb_signaling_regs dut_u (.sys_clk(sys_clk), .reset(reset), .channel_signal_enable(channel_signal_enable),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_rd_ack(cpu_rd_ack), .cpu_addr_miss(cpu_addr_miss), .rx_sig_we(rx_sig_we), .rx_sig_ch(rx_sig_ch),
    .rx_sig_c(rx_sig_c), .rx_sig_d(rx_sig_d), .tx_hwy_sync(tx_hwy_sync), .tx_hwy_bit_en(tx_hwy_bit_en),
    .tx_hwy_bit(tx_hwy_bit), .tx_ins_req(tx_ins_req), .tx_ins_ch(tx_ins_ch), .tx_ins_valid(tx_ins_valid),
    .tx_ins_en(tx_ins_en), .tx_ins_a(tx_ins_a), .tx_ins_b(tx_ins_b), .tx_ins_c(tx_ins_c));
  dsb_hwy_src hwy_u (.sys_clk(sys_clk), .sync(tx_hwy_sync), .bit_en(tx_hwy_bit_en), .hbit(tx_hwy_bit));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task chk(input [7:0] got, input [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input [8:0] a, input [7:0] d);
    @(negedge sys_clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge sys_clk);
    cpu_wr = 1'b0;
  endtask
  task rd(input [8:0] a, input [7:0] exp, input miss);
    @(negedge sys_clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge sys_clk);
    cpu_rd = 1'b0;
    chk(cpu_rdata, exp);
    chk({6'h00, cpu_rd_ack, cpu_addr_miss}, {6'h00, 1'b1, miss});
  endtask
  task rx_put(input [4:0] ch, input c, input d);
    @(negedge sys_clk);
    {rx_sig_ch, rx_sig_c, rx_sig_d, rx_sig_we} = {ch, c, d, 1'b1};
    @(negedge sys_clk);
    rx_sig_we = 1'b0;
  endtask
  task ins(input [4:0] ch, input [7:0] exp);
    @(negedge sys_clk);
    tx_ins_ch = ch;
    tx_ins_req = 1'b1;
    @(negedge sys_clk);
    tx_ins_req = 1'b0;
    chk({3'h0, tx_ins_valid, tx_ins_en, tx_ins_a, tx_ins_b, tx_ins_c}, exp);
  endtask
  task t_reset_map;
    int i;
    for (i = 0; i < 13; i++) rd(regs[i], 8'h00, 1'b0);
    wr(9'h1DA, 8'hFF);
    chk({7'h00, cpu_addr_miss}, 8'h01);
    rd(9'h1DA, 8'h00, 1'b1);
    rd(9'h188, 8'h00, 1'b1);
  endtask
  task t_rx;
    channel_signal_enable = 24'hFFFFFF;
    rx_put(5'h10, 1'b1, 1'b1);
    rx_put(5'h08, 1'b1, 1'b1);
    rx_put(5'h18, 1'b1, 1'b0);
    rd(9'h189, 8'h80, 1'b0);
    rd(9'h18D, 8'h80, 1'b0);
    rd(9'h18C, 8'h80, 1'b0);
    rd(9'h18A, 8'h80, 1'b0);
    rd(9'h18E, 8'h00, 1'b0);
    channel_signal_enable[15] = 1'b0;
    rd(9'h189, 8'h00, 1'b0);
    rd(9'h18D, 8'h00, 1'b0);
    wr(9'h189, 8'hFF);
    rd(9'h189, 8'h7F, 1'b0);
    rx_put(5'h10, 1'b1, 1'b1);
    rd(9'h189, 8'h7F, 1'b0);
  endtask
  task t_tx;
    // Channel 1 off: its highway load must be dropped
    channel_signal_enable = 24'hFFFFFE;
    hwy_u.send(24'h800003, 24'h000180, 24'h808001, 24'h000000, 0);
    repeat (3) @(negedge sys_clk);
    rd(9'h1D0, 8'h02, 1'b0);
    rd(9'h1D2, 8'h80, 1'b0);
    rd(9'h1D4, 8'h80, 1'b0);
    rd(9'h1D5, 8'h01, 1'b0);
    rd(9'h1D9, 8'h80, 1'b0);
    ins(5'h18, 8'h1C);
    ins(5'h10, 8'h19);
    ins(5'h09, 8'h1A);
    channel_signal_enable[8] = 1'b0;
    @(negedge sys_clk);
    chk({3'h0, tx_ins_valid, tx_ins_en, tx_ins_a, tx_ins_b, tx_ins_c}, 8'h00);
    channel_signal_enable[8] = 1'b1;
    wr(9'h1D8, 8'h01);
    rd(9'h1D8, 8'h01, 1'b0);
    ins(5'h01, 8'h10);
    ins(5'h19, 8'h10);
    hwy_u.send(24'h000004, 24'h000000, 24'h000000, 24'h000000, 2);
    repeat (3) @(negedge sys_clk);
    rd(9'h1D0, 8'h04, 1'b0);
    rd(9'h1D8, 8'h01, 1'b0);
  endtask
  task give_verdict;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {reset, cpu_wr, cpu_rd, rx_sig_we, rx_sig_c, rx_sig_d, tx_ins_req} = 7'h40;
    {channel_signal_enable, cpu_addr, cpu_wdata, rx_sig_ch, tx_ins_ch} = 51'h0;
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    t_reset_map;
    t_rx;
    t_tx;
    give_verdict;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    fails++;
    give_verdict;
  end
endmodule
